// ### include/cbtc_pkg.sv
// Purpose: Shared constants and types for the bus trace capture block
// Assumes: One system clock; the processor's two-phase bus states map onto clock edges
// Notes: Cycle-type field layout and pod routing widths live here
package cbtc_pkg;
  // Bus widths
  localparam int unsigned CBTC_ADDR_W = 24;
  localparam int unsigned CBTC_DATA_W = 16;
  localparam int unsigned CBTC_STAT_W = 8;
  localparam int unsigned CBTC_CTRL_W = 4;
  // Cycle-type field bit positions, low bit first
  localparam int unsigned CBTC_ST_STAT_ONE = 0;
  localparam int unsigned CBTC_ST_UBE = 1;
  localparam int unsigned CBTC_ST_BYTE_SEL = 2;
  localparam int unsigned CBTC_ST_STAT_ZERO = 3;
  localparam int unsigned CBTC_ST_MIO = 4;
  localparam int unsigned CBTC_ST_CODE_ACK = 5;
  localparam int unsigned CBTC_ST_LOCK = 6;
  localparam int unsigned CBTC_ST_HOLD_ACK = 7;
  // Timing pod five control bit positions
  localparam int unsigned CBTC_P5_STAT_ZERO = 0;
  localparam int unsigned CBTC_P5_STAT_ONE = 1;
  localparam int unsigned CBTC_P5_RDY = 2;
  localparam int unsigned CBTC_P5_RST = 3;
  // Highest supported processor input clock, in MHz
  localparam int unsigned CBTC_MAX_CLK_MHZ = 50;
  // Wait-state counter width
  localparam int unsigned CBTC_WAIT_W = 8;
  localparam logic [CBTC_WAIT_W-1:0] CBTC_WAIT_ONE = 8'h01;
  localparam logic [CBTC_WAIT_W-1:0] CBTC_WAIT_MAX = 8'hFF;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    CBTC_IDLE = 4'h1,
    CBTC_STATUS = 4'h2,
    CBTC_COMMAND = 4'h4,
    CBTC_STROBE = 4'h8
  } cbtc_state_t;
endpackage

// ### design/cbtc_data_latch.sv
// Purpose: Two-stage data bus latch, falling edge then rising edge
// Assumes: ref_clk is the processor input clock
// Notes: Stage two is read one rising edge after it loads the closing-edge sample
`timescale 1ns/1ns
`default_nettype none
module cbtc_data_latch
  import cbtc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Raw and latched data
  input wire logic [CBTC_DATA_W-1:0] data_in,
  output logic [CBTC_DATA_W-1:0] data_out
);
  logic [CBTC_DATA_W-1:0] stage_one; // Falling-edge capture
  logic [CBTC_DATA_W-1:0] next_stage_one;
  logic [CBTC_DATA_W-1:0] next_data_out;

  // Next values for both stages
  always_comb begin
    next_stage_one = data_in;
    next_data_out = stage_one;
    if (rst) begin
      next_stage_one = '0;
      next_data_out = '0;
    end
  end

  // First stage on falling edge
  always_ff @(negedge ref_clk) begin
    stage_one <= next_stage_one;
  end

  // Second stage on rising edge
  always_ff @(posedge ref_clk) begin
    data_out <= next_data_out;
  end
endmodule
`default_nettype wire

// ### design/cbtc_capture.sv
// Purpose: Bus-state capture front end presenting one sample per bus cycle
// Assumes: ref_clk is the processor input clock; inputs synchronous to it
// Notes: Bus cycle is a status phase then command phases, each two clock periods
`timescale 1ns/1ns
`default_nettype none
module cbtc_capture
  import cbtc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Mode select: high for timing mode
  input wire logic timing_mode,
  // Processor bus, status lines active low
  input wire logic bus_status_zero_n,
  input wire logic bus_status_one_n,
  input wire logic ready_n,
  input wire logic cpu_reset,
  input wire logic upper_byte_enable_n,
  input wire logic mem_or_io,
  input wire logic code_or_irq_ack,
  input wire logic lock_n,
  input wire logic hold_acknowledge,
  input wire logic [CBTC_ADDR_W-1:0] cpu_address_bus,
  input wire logic [CBTC_DATA_W-1:0] cpu_data_bus,
  // State-mode sample
  output logic sample_strobe,
  output logic [CBTC_ADDR_W-1:0] sample_address,
  output logic [CBTC_STAT_W-1:0] sample_status,
  output logic [CBTC_DATA_W-1:0] pod1_data,
  output logic [CBTC_WAIT_W-1:0] sample_waits,
  // Timing-mode pods
  output logic [CBTC_DATA_W-1:0] pod4_data,
  output logic [CBTC_CTRL_W-1:0] pod5_ctrl,
  output logic [CBTC_ADDR_W-1:0] timing_address,
  output logic [CBTC_STAT_W-1:0] timing_status
);
  cbtc_state_t state; // Sequencer state
  cbtc_state_t next_state;
  logic phase; // Zero in first clock of a bus state
  logic next_phase;
  logic [1:0] start_status; // Status lines caught at cycle start
  logic [1:0] next_start_status;
  logic [CBTC_ADDR_W-1:0] addr_hold; // Address of cycle in progress
  logic [CBTC_ADDR_W-1:0] next_addr_hold;
  logic [CBTC_STAT_W-1:0] stat_hold; // Status of cycle in progress
  logic [CBTC_STAT_W-1:0] next_stat_hold;
  logic [CBTC_WAIT_W-1:0] wait_cnt; // Extra command phases so far
  logic [CBTC_WAIT_W-1:0] next_wait_cnt;
  logic [CBTC_ADDR_W-1:0] next_sample_address;
  logic [CBTC_STAT_W-1:0] next_sample_status;
  logic [CBTC_DATA_W-1:0] next_pod1_data;
  logic [CBTC_WAIT_W-1:0] next_sample_waits;
  logic strobe_q; // High in the same cycle the sample is published
  logic next_strobe_q;
  logic ready_fall; // Ready seen at the falling edge closing the state
  logic next_ready_fall;
  logic [CBTC_DATA_W-1:0] data_late; // Second-stage latch output
  logic [CBTC_STAT_W-1:0] live_status; // Cycle-type field from live pins
  logic status_active;

  // Double latch of the data bus
  cbtc_data_latch u_data_latch (
    .ref_clk(ref_clk),
    .rst(rst),
    .data_in(cpu_data_bus),
    .data_out(data_late)
  );

  // Cycle-type field assembly, fixed bit order
  always_comb begin
    live_status = '0;
    live_status[CBTC_ST_STAT_ONE] = bus_status_one_n;
    live_status[CBTC_ST_UBE] = upper_byte_enable_n;
    live_status[CBTC_ST_BYTE_SEL] = cpu_address_bus[0];
    live_status[CBTC_ST_STAT_ZERO] = bus_status_zero_n;
    live_status[CBTC_ST_MIO] = mem_or_io;
    live_status[CBTC_ST_CODE_ACK] = code_or_irq_ack;
    live_status[CBTC_ST_LOCK] = lock_n;
    live_status[CBTC_ST_HOLD_ACK] = hold_acknowledge;
  end

  // Either status line low starts a cycle; no cycle-type filter
  assign status_active = !bus_status_zero_n || !bus_status_one_n;

  // Ready sampled on the falling edge that ends the state
  always_comb begin
    next_ready_fall = !ready_n;
    if (rst) begin
      next_ready_fall = 1'b0;
    end
  end

  // Falling-edge sampler for ready
  always_ff @(negedge ref_clk) begin
    ready_fall <= next_ready_fall;
  end

  // Sequencer next-state and capture logic
  always_comb begin
    next_state = state;
    next_phase = ~phase;
    next_start_status = start_status;
    next_addr_hold = addr_hold;
    next_stat_hold = stat_hold;
    next_wait_cnt = wait_cnt;
    next_sample_address = sample_address;
    next_sample_status = sample_status;
    next_pod1_data = pod1_data;
    next_sample_waits = sample_waits;
    next_strobe_q = 1'b0;
    unique case (state)
      CBTC_IDLE: begin
        next_phase = 1'b0;
        if (status_active) begin
          // Catch both status values at the start
          next_start_status = {bus_status_one_n, bus_status_zero_n};
          next_state = CBTC_STATUS;
          next_phase = 1'b1;
        end
      end
      CBTC_STATUS: begin
        if (phase) begin
          // End of status phase: latch address and status
          next_addr_hold = cpu_address_bus;
          next_stat_hold = live_status;
          next_stat_hold[CBTC_ST_STAT_ONE] = start_status[1];
          next_stat_hold[CBTC_ST_STAT_ZERO] = start_status[0];
          next_wait_cnt = '0;
          next_state = CBTC_COMMAND;
        end
      end
      CBTC_COMMAND: begin
        if (phase) begin
          if (ready_fall) begin
            // Ready found: close cycle, strobe next state
            next_state = CBTC_STROBE;
          end else if (wait_cnt != CBTC_WAIT_MAX) begin
            // One more command phase is one wait state
            next_wait_cnt = wait_cnt + CBTC_WAIT_ONE;
          end
        end
      end
      CBTC_STROBE: begin
        // Stage two now holds data from the closing falling edge
        next_sample_address = addr_hold;
        next_sample_status = stat_hold;
        next_pod1_data = data_late;
        next_sample_waits = wait_cnt;
        // Strobe stands in the same cycle as the newly published sample
        next_strobe_q = 1'b1;
        // Then back to idle or a pipelined start
        next_phase = 1'b0;
        next_state = CBTC_IDLE;
        if (status_active) begin
          next_start_status = {bus_status_one_n, bus_status_zero_n};
          next_state = CBTC_STATUS;
          next_phase = 1'b1;
        end
      end
      default: begin
        next_state = CBTC_IDLE;
        next_phase = 1'b0;
      end
    endcase
    // Processor reset or timing mode abandons tracking
    if (rst || cpu_reset || timing_mode) begin
      next_state = CBTC_IDLE;
      next_phase = 1'b0;
      next_wait_cnt = '0;
      // An abandoned cycle publishes nothing
      next_strobe_q = 1'b0;
      next_sample_address = sample_address;
      next_sample_status = sample_status;
      next_pod1_data = pod1_data;
      next_sample_waits = sample_waits;
    end
    if (rst) begin
      next_start_status = '0;
      next_addr_hold = '0;
      next_stat_hold = '0;
      next_sample_address = '0;
      next_sample_status = '0;
      next_pod1_data = '0;
      next_sample_waits = '0;
    end
  end

  // Sequencer registers; purely synchronous design meets the clock limit
  always_ff @(posedge ref_clk) begin
    state <= next_state;
    phase <= next_phase;
    start_status <= next_start_status;
    addr_hold <= next_addr_hold;
    stat_hold <= next_stat_hold;
    wait_cnt <= next_wait_cnt;
    strobe_q <= next_strobe_q;
    sample_address <= next_sample_address;
    sample_status <= next_sample_status;
    pod1_data <= next_pod1_data;
    sample_waits <= next_sample_waits;
  end

  // Composite strobe, never the raw clock; suppressed in reset
  assign sample_strobe = strobe_q && !cpu_reset && !timing_mode;

  // Timing mode: straight pass-through so relative timing holds
  always_comb begin
    pod4_data = '0;
    pod5_ctrl = '0;
    timing_address = '0;
    timing_status = '0;
    if (timing_mode) begin
      pod4_data = cpu_data_bus;
      pod5_ctrl[CBTC_P5_STAT_ZERO] = bus_status_zero_n;
      pod5_ctrl[CBTC_P5_STAT_ONE] = bus_status_one_n;
      pod5_ctrl[CBTC_P5_RDY] = ready_n;
      pod5_ctrl[CBTC_P5_RST] = cpu_reset;
      timing_address = cpu_address_bus;
      timing_status = live_status;
    end
  end
  // In state mode pods four and five stay zero; pod one holds data
endmodule
`default_nettype wire

// ### dv/cbtc_capture_props.sv
// Purpose: Concurrent checks on the bus trace capture ports
// Assumes: All signals sampled on rising ref_clk
// Notes: Bound onto every capture instance
`timescale 1ns/1ns
`default_nettype none
module cbtc_capture_props
  import cbtc_pkg::*;
(
  // Clock, reset, mode
  input wire logic ref_clk, rst, timing_mode,
  // Processor side
  input wire logic bus_status_zero_n, bus_status_one_n, ready_n, cpu_reset,
  input wire logic upper_byte_enable_n, mem_or_io, code_or_irq_ack, lock_n, hold_acknowledge,
  input wire logic [CBTC_ADDR_W-1:0] cpu_address_bus,
  input wire logic [CBTC_DATA_W-1:0] cpu_data_bus,
  // Design outputs
  input wire logic sample_strobe,
  input wire logic [CBTC_ADDR_W-1:0] sample_address, timing_address,
  input wire logic [CBTC_STAT_W-1:0] sample_status, timing_status,
  input wire logic [CBTC_DATA_W-1:0] pod1_data, pod4_data,
  input wire logic [CBTC_CTRL_W-1:0] pod5_ctrl
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_ONE_STROBE: assert property (sample_strobe |=> !sample_strobe [*3])
    else $error("strobe longer than one cycle or too close");
  AST_TIMING_QUIET: assert property (timing_mode |-> !sample_strobe)
    else $error("strobe in timing mode");
  AST_RESET_QUIET: assert property (cpu_reset |-> !sample_strobe)
    else $error("strobe during processor reset");
  AST_ABANDON: assert property ($fell(cpu_reset) |-> !sample_strobe [*4])
    else $error("cycle survived processor reset");
  AST_CAUSE: assert property (sample_strobe |-> !$past(cpu_reset) && !$past(cpu_reset, 2))
    else $error("strobe not built from a clean cycle");
  AST_HOLD: assert property (!sample_strobe |-> $stable(sample_address) &&
    $stable(sample_status) && $stable(pod1_data))
    else $error("sample changed without a strobe");
  AST_POD4: assert property (timing_mode |-> pod4_data == cpu_data_bus &&
    timing_address == cpu_address_bus)
    else $error("timing pass-through mismatch");
  AST_POD5: assert property (timing_mode |-> pod5_ctrl ==
    {cpu_reset, ready_n, bus_status_one_n, bus_status_zero_n})
    else $error("pod five control mismatch");
  AST_STATE_PODS: assert property (!timing_mode |-> pod4_data == '0 && pod5_ctrl == '0)
    else $error("timing pods active in state mode");
  AST_TSTAT: assert property (timing_mode |-> timing_status == {hold_acknowledge,
    lock_n, code_or_irq_ack, mem_or_io, bus_status_zero_n, cpu_address_bus[0],
    upper_byte_enable_n, bus_status_one_n})
    else $error("status field order wrong");
endmodule
bind cbtc_capture cbtc_capture_props u_props (.*);
`default_nettype wire

// ### dv/cbtc_cpu_model.sv
// Purpose: Behavioural processor bus master facing the capture block
// Assumes: Drives on falling ref_clk only
// Notes: Released data bus toggles so stale values never look valid
`timescale 1ns/1ns
`default_nettype none
module cbtc_cpu_model
  import cbtc_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Bus drive
  output logic bus_status_zero_n, bus_status_one_n, ready_n,
  output logic upper_byte_enable_n, mem_or_io, code_or_irq_ack, lock_n, hold_acknowledge,
  output logic [CBTC_ADDR_W-1:0] cpu_address_bus,
  output logic [CBTC_DATA_W-1:0] cpu_data_bus
);
  logic drv; // High while data is really driven
  // Idle bus: no status active, ready off
  initial begin
    {bus_status_one_n, bus_status_zero_n, ready_n, drv} = 4'hE;
    {upper_byte_enable_n, mem_or_io, code_or_irq_ack, lock_n, hold_acknowledge} = 5'h1F;
    cpu_address_bus = 24'h000000;
    cpu_data_bus = 16'h0000;
  end
  // Floating data changes every cycle
  always @(negedge ref_clk) if (!drv) cpu_data_bus <= ~cpu_data_bus;
  // Status state, then command states, w of them not ready
  task automatic bus_cycle(input logic [CBTC_ADDR_W-1:0] a, input logic [CBTC_DATA_W-1:0] d,
                           input logic [CBTC_STAT_W-1:0] st, input int unsigned w);
    @(negedge ref_clk);
    {hold_acknowledge, lock_n, code_or_irq_ack, mem_or_io, bus_status_zero_n} <= st[7:3];
    {upper_byte_enable_n, bus_status_one_n} <= st[1:0];
    cpu_address_bus <= a;
    repeat (2) @(negedge ref_clk);
    {bus_status_one_n, bus_status_zero_n} <= 2'h3;
    repeat (2 * w) @(negedge ref_clk);
    ready_n <= 1'b0;
    drv = 1'b1;
    cpu_data_bus <= d;
    // Ready and data are sampled here, then released
    @(negedge ref_clk);
    ready_n <= 1'b1;
    drv = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/cbtc_capture_tb_top.sv
// Purpose: Self-checking bench for the bus trace capture block
// Assumes: Bench drives mode and resets on falling ref_clk
// Notes: Row table for cycle types, hand tests after it
`timescale 1ns/1ns
`default_nettype none
module cbtc_capture_tb_top
  import cbtc_pkg::*;
;
  // One bus cycle; the sample must echo it
  typedef struct {logic [23:0] a; logic [15:0] d; logic [7:0] st; int unsigned w;} cbtc_row_t;
  cbtc_row_t rows [9] = '{'{24'h100000, 16'h0001, 8'h40, 0}, '{24'h200002, 16'h8002, 8'h50, 1},
    '{24'h00FFF5, 16'h1234, 8'h5C, 0}, '{24'hFFFFFE, 16'hFFFF, 8'h53, 2},
    '{24'h000010, 16'h5555, 8'h68, 0}, '{24'h000020, 16'hAAAA, 8'h61, 3},
    '{24'h0ABCD0, 16'h0F0F, 8'h78, 0}, '{24'h333332, 16'hF0F0, 8'h18, 1},
    '{24'h444444, 16'h4321, 8'hD8, 0}};
  logic ref_clk, rst, timing_mode, cpu_reset;
  wire logic bus_status_zero_n, bus_status_one_n, ready_n, upper_byte_enable_n, mem_or_io;
  wire logic code_or_irq_ack, lock_n, hold_acknowledge, sample_strobe;
  wire logic [23:0] cpu_address_bus, sample_address, timing_address;
  wire logic [15:0] cpu_data_bus, pod1_data, pod4_data;
  wire logic [7:0] sample_status, sample_waits, timing_status;
  wire logic [3:0] pod5_ctrl;
  int fails = 0, num_checks = 0, strobes = 0, cycles = 0, base;
  cbtc_capture DUT (.*);
  cbtc_cpu_model u_cpu (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Strobe counter and hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (sample_strobe === 1'b1) strobes++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst, timing_mode, cpu_reset} = 3'h4;
    repeat (2) @(negedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check(32'(sample_address), 32'h0, "reset address");
    foreach (rows[i]) begin
      u_cpu.bus_cycle(rows[i].a, rows[i].d, rows[i].st, rows[i].w);
      // Sample is published on the second rising edge after the closing edge
      repeat (2) @(negedge ref_clk);
      check(32'(sample_strobe), 32'h1, "strobe");
      check(32'(sample_address), 32'(rows[i].a), "address");
      check(32'(sample_status), 32'(rows[i].st), "status");
      check(32'(pod1_data), 32'(rows[i].d), "data");
      check(32'(sample_waits), rows[i].w, "waits");
    end
    @(negedge ref_clk);
    check(32'(strobes), 32'd9, "strobe count");
    // Processor reset in mid-cycle
    base = strobes;
    fork
      u_cpu.bus_cycle(24'h123456, 16'hBEEF, 8'h58, 2);
      begin
        repeat (4) @(negedge ref_clk);
        cpu_reset <= 1'b1;
        @(negedge ref_clk);
        cpu_reset <= 1'b0;
      end
    join
    repeat (3) @(negedge ref_clk);
    check(32'(strobes), 32'(base), "abort strobes");
    check(32'(sample_address), 32'h444444, "abort address");
    // Back-to-back cycles
    u_cpu.bus_cycle(24'h0ABCD0, 16'h1357, 8'h78, 0);
    u_cpu.bus_cycle(24'h0ABCD4, 16'h2468, 8'h61, 1);
    repeat (2) @(negedge ref_clk);
    check(32'(sample_address), 32'h0ABCD4, "b2b address");
    check(32'(pod1_data), 32'h2468, "b2b data");
    @(negedge ref_clk);
    check(32'(strobes), 32'(base + 2), "b2b strobes");
    // Timing mode passes the bus straight through
    timing_mode <= 1'b1;
    base = strobes;
    u_cpu.bus_cycle(24'h5A5A5A, 16'hC3C3, 8'h40, 0);
    @(negedge ref_clk);
    check(32'(pod4_data), 32'(cpu_data_bus), "pod4");
    check(32'(pod5_ctrl), 32'({cpu_reset, ready_n, 2'h3}), "pod5");
    check(32'(strobes), 32'(base), "timing strobes");
    timing_mode <= 1'b0;
    @(negedge ref_clk);
    check(32'(pod4_data), 32'h0, "state pod4");
    rst <= 1'b1;
    repeat (2) @(negedge ref_clk);
    check(32'(sample_address), 32'h0, "second reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
